// [design/iasu_pkg.sv]
package iasu_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Widths and register map.

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;

  localparam logic [11:0] OFF_FIRST_SRC = 12'h000;
  localparam logic [11:0] OFF_SECOND_SRC = 12'h004;
  localparam logic [11:0] OFF_COMMAND = 12'h008;
  localparam logic [11:0] OFF_RESULT = 12'h00c;
  localparam logic [11:0] OFF_FLAGS = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;
  localparam logic [11:0] OFF_EXEC_COUNT = 12'h018;
  localparam logic [11:0] OFF_UNDEF_COUNT = 12'h01c;
  localparam logic [11:0] OFF_PREVIEW = 12'h020;

  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [3:0] INDEX_RST = 4'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Register numbers and immediate limits.

  localparam logic [3:0] LOW_REG_MAX = 4'h7;
  localparam logic [3:0] REG_SP = 4'hd;
  localparam logic [3:0] REG_PC = 4'hf;
  localparam logic [9:0] IMM_MAX_BASE = 10'h3fc;
  localparam logic [9:0] IMM_MAX_SP = 10'h1fc;
  localparam logic [9:0] IMM_MAX_SMALL = 10'h007;
  localparam logic [9:0] IMM_MAX_BYTE = 10'h0ff;
  localparam logic [9:0] IMM_ZERO = 10'h000;

  //////////////////////////////////////////////////////////////////////////////
  // Types.

  typedef enum logic [3:0] {
    sum_with_carry_op = 4'h0,
    add_op = 4'h1,
    flagged_sum_op = 4'h2,
    negate_from_zero_op = 4'h3,
    difference_with_carry_op = 4'h4,
    sub_op = 4'h5,
    flagged_difference_op = 4'h6
  } iasu_op_t;

  typedef struct packed {
    logic [3:0] spare;
    logic [9:0] imm;
    logic rd_omit;
    logic use_imm;
    logic [3:0] second_source_operand;
    logic [3:0] first_source_operand;
    logic [3:0] rd;
    iasu_op_t op;
  } iasu_cmd_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } iasu_flags_t;

  typedef struct packed {
    logic [3:0] rd;
    logic collide;
    logic wrote;
    logic undef;
  } iasu_status_t;

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    logic cin;
  } iasu_addin_t;

  typedef struct packed {
    logic [31:0] first_src;
    logic [31:0] second_src;
    iasu_cmd_t cmd;
    logic [31:0] result;
    iasu_flags_t flags;
    iasu_status_t status;
    logic [31:0] exec_count;
    logic [31:0] undef_count;
    logic [3:0] rd_idx;
    logic rd_we;
    logic undef_pulse;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } iasu_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic is_low(input logic [3:0] r);
    return r <= LOW_REG_MAX;
  endfunction : is_low

  function automatic logic is_word_multiple(input logic [9:0] imm);
    return imm[1:0] == 2'b00;
  endfunction : is_word_multiple

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge_strb

endpackage : iasu_pkg

// [design/iasu_adder.sv]
`timescale 1ns/1ps
module iasu_adder (
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  input wire logic cin_i,
  output logic [31:0] sum_o,
  output logic carry_o,
  output logic ovf_o
);

  logic [32:0] full;

  assign full = {1'b0, a_i} + {1'b0, b_i} + {32'h0000_0000, cin_i};
  assign sum_o = full[31:0];
  // Unsigned carry out and signed overflow of the addition.
  assign carry_o = full[32];
  assign ovf_o = (a_i[31] == b_i[31]) && (sum_o[31] != a_i[31]);

endmodule : iasu_adder

// [design/iasu_legal.sv]
`timescale 1ns/1ps
module iasu_legal (
  input wire iasu_pkg::iasu_cmd_t cmd_i,
  output logic legal_o,
  output logic [3:0] rd_o
);

  logic [3:0] rn;
  logic [3:0] rm;
  logic [9:0] imm;
  logic base_ok;
  logic sp_ok;

  assign rn = cmd_i.first_source_operand;
  assign rm = cmd_i.second_source_operand;
  assign imm = cmd_i.imm;
  // A missing destination falls back to the first source.
  assign rd_o = cmd_i.rd_omit ? rn : cmd_i.rd;
  assign base_ok = iasu_pkg::is_low(rd_o)
                   && (rn == iasu_pkg::REG_SP || rn == iasu_pkg::REG_PC)
                   && imm <= iasu_pkg::IMM_MAX_BASE
                   && iasu_pkg::is_word_multiple(imm);
  assign sp_ok = rd_o == iasu_pkg::REG_SP && rn == iasu_pkg::REG_SP
                 && imm <= iasu_pkg::IMM_MAX_SP
                 && iasu_pkg::is_word_multiple(imm);

  always_comb begin
    legal_o = 1'b0;
    unique case (cmd_i.op)
      iasu_pkg::sum_with_carry_op, iasu_pkg::difference_with_carry_op: begin
        legal_o = !cmd_i.use_imm && iasu_pkg::is_low(rd_o)
                  && iasu_pkg::is_low(rn) && iasu_pkg::is_low(rm)
                  && rd_o == rn;
      end
      iasu_pkg::add_op: begin
        if (cmd_i.use_imm) begin
          legal_o = base_ok || sp_ok;
        end else begin
          legal_o = rd_o == rn
                    && !(rn == iasu_pkg::REG_PC && rm == iasu_pkg::REG_PC);
        end
      end
      iasu_pkg::flagged_sum_op, iasu_pkg::flagged_difference_op: begin
        if (cmd_i.use_imm) begin
          legal_o = iasu_pkg::is_low(rd_o) && iasu_pkg::is_low(rn)
                    && (imm <= iasu_pkg::IMM_MAX_SMALL
                        || (imm <= iasu_pkg::IMM_MAX_BYTE && rd_o == rn));
        end else begin
          legal_o = iasu_pkg::is_low(rd_o) && iasu_pkg::is_low(rn)
                    && iasu_pkg::is_low(rm);
        end
      end
      iasu_pkg::negate_from_zero_op: begin
        legal_o = cmd_i.use_imm && imm == iasu_pkg::IMM_ZERO
                  && iasu_pkg::is_low(rd_o) && iasu_pkg::is_low(rn);
      end
      iasu_pkg::sub_op: begin
        legal_o = cmd_i.use_imm && sp_ok;
      end
      default: begin
        legal_o = 1'b0;
      end
    endcase
  end

endmodule : iasu_legal

// [design/iasu_top.sv]
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Function
// - Carry-add sums both sources plus the carry flag, writes and sets NZCV.
// - Plain add sums source and register or immediate, flags untouched.
// - Flag-setting add gives the plain sum and also updates NZCV.
// - Negate computes zero minus the source, sets NZCV, immediate only #0.
// - Carry-subtract takes first minus second minus one more if carry set.
// - Plain subtract takes source minus immediate only, no flags.
// - Flag-setting subtract gives the plain difference and updates NZCV.
// - A missing destination means the first source is the destination.
// - Only the tabulated operand forms pass, most restricted to R0 to R7.
// - Plain register add allows R0 to R15, rd equals rn, not both PC.
// - Add on an SP or PC base writes a low register, immediate 0-1020 by 4.
// - SP adjust add and subtract use SP both ways, immediate 0-508 by 4.
// - Flagged immediates 0-7 any low pair, 0-255 only when rd equals rn.
// - Carry forms read the carry left by earlier flag-setting work.
module iasu_top (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic issue_valid_i,
  input wire iasu_pkg::iasu_cmd_t issue_cmd_i,
  input wire logic [31:0] issue_first_src_i,
  input wire logic [31:0] issue_second_src_i,
  output logic [31:0] result_o,
  output iasu_pkg::iasu_flags_t flags_o,
  output logic [3:0] rd_idx_o,
  output logic rd_we_o,
  output logic undef_o
);

  //////////////////////////////////////////////////////////////////////////////
  // State and bus qualifiers.

  iasu_pkg::iasu_state_t s_q;
  iasu_pkg::iasu_state_t s_d;

  logic apb_wait;
  logic apb_take;
  logic apb_wr;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic cmd_wr;
  iasu_pkg::iasu_cmd_t apb_cmd;
  logic go;
  iasu_pkg::iasu_cmd_t x_cmd;
  logic [31:0] x_first;
  logic [31:0] x_second;
  logic x_legal;
  logic [3:0] x_rd;
  logic pv_legal;
  logic [3:0] pv_rd;
  iasu_pkg::iasu_addin_t add_in;
  logic [31:0] sum;
  logic carry;
  logic ovf;

  // The slave inserts one wait cycle so that read data comes from a flop.
  assign apb_wait = psel_i && penable_i && !s_q.pready;
  assign apb_take = psel_i && penable_i && s_q.pready;
  assign apb_wr = apb_take && pwrite_i && addr_hit;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode.

  function automatic logic is_mapped(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (addr)
      iasu_pkg::OFF_FIRST_SRC,
      iasu_pkg::OFF_SECOND_SRC,
      iasu_pkg::OFF_COMMAND,
      iasu_pkg::OFF_RESULT,
      iasu_pkg::OFF_FLAGS,
      iasu_pkg::OFF_STATUS,
      iasu_pkg::OFF_EXEC_COUNT,
      iasu_pkg::OFF_UNDEF_COUNT,
      iasu_pkg::OFF_PREVIEW: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : is_mapped

  assign addr_hit = is_mapped(paddr_i);

  always_comb begin
    rd_mux = iasu_pkg::DATA_RST;
    unique case (paddr_i)
      iasu_pkg::OFF_FIRST_SRC: begin
        rd_mux = s_q.first_src;
      end
      iasu_pkg::OFF_SECOND_SRC: begin
        rd_mux = s_q.second_src;
      end
      iasu_pkg::OFF_COMMAND: begin
        rd_mux = s_q.cmd;
      end
      iasu_pkg::OFF_RESULT: begin
        rd_mux = s_q.result;
      end
      iasu_pkg::OFF_FLAGS: begin
        rd_mux = {28'h000_0000, s_q.flags};
      end
      iasu_pkg::OFF_STATUS: begin
        rd_mux = {25'h000_0000, s_q.status};
      end
      iasu_pkg::OFF_EXEC_COUNT: begin
        rd_mux = s_q.exec_count;
      end
      iasu_pkg::OFF_UNDEF_COUNT: begin
        rd_mux = s_q.undef_count;
      end
      iasu_pkg::OFF_PREVIEW: begin
        rd_mux = {24'h00_0000, pv_rd, 3'b000, pv_legal};
      end
      default: begin
        rd_mux = iasu_pkg::DATA_RST;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command selection.

  // The decode-stage port wins a same-cycle clash; the bus command is then
  // stored but not run, which software sees in the status register.
  assign cmd_wr = apb_wr && paddr_i == iasu_pkg::OFF_COMMAND;
  assign apb_cmd = iasu_pkg::iasu_cmd_t'(
    iasu_pkg::merge_strb(s_q.cmd, pwdata_i, pstrb_i));
  assign go = issue_valid_i || cmd_wr;
  assign x_cmd = issue_valid_i ? issue_cmd_i : apb_cmd;
  assign x_first = issue_valid_i ? issue_first_src_i : s_q.first_src;
  assign x_second = issue_valid_i ? issue_second_src_i : s_q.second_src;

  iasu_legal u_legal (
    .cmd_i(x_cmd),
    .legal_o(x_legal),
    .rd_o(x_rd)
  );

  // A second checker judges the stored command, which software reads at the preview offset.
  iasu_legal u_preview (
    .cmd_i(s_q.cmd),
    .legal_o(pv_legal),
    .rd_o(pv_rd)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Operand steering into the single adder.

  function automatic iasu_pkg::iasu_addin_t steer(
    input iasu_pkg::iasu_cmd_t cmd,
    input logic [31:0] first,
    input logic [31:0] second,
    input logic carry_in
  );
    iasu_pkg::iasu_addin_t r;
    logic [31:0] opnd;
    opnd = cmd.use_imm ? {22'h00_0000, cmd.imm} : second;
    r.a = first;
    r.b = opnd;
    r.cin = 1'b0;
    unique case (cmd.op)
      iasu_pkg::sum_with_carry_op: begin
        r.b = second;
        r.cin = carry_in;
      end
      iasu_pkg::add_op, iasu_pkg::flagged_sum_op: begin
        r.cin = 1'b0;
      end
      iasu_pkg::negate_from_zero_op: begin
        r.a = iasu_pkg::DATA_RST;
        r.b = ~first;
        r.cin = 1'b1;
      end
      iasu_pkg::difference_with_carry_op: begin
        // One more is taken off while carry is set, so the carry-in is its
        // inverse.
        r.b = ~second;
        r.cin = ~carry_in;
      end
      iasu_pkg::sub_op, iasu_pkg::flagged_difference_op: begin
        r.b = ~opnd;
        r.cin = 1'b1;
      end
      default: begin
        r.cin = 1'b0;
      end
    endcase
    return r;
  endfunction : steer

  function automatic logic sets_flags(input iasu_pkg::iasu_op_t op);
    return op == iasu_pkg::sum_with_carry_op
           || op == iasu_pkg::flagged_sum_op
           || op == iasu_pkg::negate_from_zero_op
           || op == iasu_pkg::difference_with_carry_op
           || op == iasu_pkg::flagged_difference_op;
  endfunction : sets_flags

  assign add_in = steer(x_cmd, x_first, x_second, s_q.flags.c);

  iasu_adder u_adder (
    .a_i(add_in.a),
    .b_i(add_in.b),
    .cin_i(add_in.cin),
    .sum_o(sum),
    .carry_o(carry),
    .ovf_o(ovf)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_d = s_q;
    s_d.rd_we = 1'b0;
    s_d.undef_pulse = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.prdata = iasu_pkg::DATA_RST;
    if (apb_wait) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !addr_hit;
      s_d.prdata = pwrite_i ? iasu_pkg::DATA_RST : rd_mux;
    end
    if (apb_wr) begin
      unique case (paddr_i)
        iasu_pkg::OFF_FIRST_SRC: begin
          s_d.first_src = iasu_pkg::merge_strb(s_q.first_src, pwdata_i,
                                               pstrb_i);
        end
        iasu_pkg::OFF_SECOND_SRC: begin
          s_d.second_src = iasu_pkg::merge_strb(s_q.second_src, pwdata_i,
                                                pstrb_i);
        end
        iasu_pkg::OFF_COMMAND: begin
          s_d.cmd = apb_cmd;
        end
        iasu_pkg::OFF_FLAGS: begin
          if (pstrb_i[0]) begin
            s_d.flags = pwdata_i[3:0];
          end
        end
        default: begin
          s_d.cmd = s_q.cmd;
        end
      endcase
    end
    if (go) begin
      s_d.status.rd = x_rd;
      s_d.status.collide = issue_valid_i && cmd_wr;
      s_d.status.wrote = x_legal;
      s_d.status.undef = !x_legal;
      if (x_legal) begin
        s_d.result = sum;
        s_d.rd_idx = x_rd;
        s_d.rd_we = 1'b1;
        s_d.exec_count = s_q.exec_count + 32'h0000_0001;
        // Plain add and subtract leave the flags alone.
        if (sets_flags(x_cmd.op)) begin
          s_d.flags.n = sum[31];
          s_d.flags.z = sum == iasu_pkg::DATA_RST;
          s_d.flags.c = carry;
          s_d.flags.v = ovf;
        end
      end else begin
        s_d.undef_pulse = 1'b1;
        s_d.undef_count = s_q.undef_count + 32'h0000_0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q.first_src <= iasu_pkg::DATA_RST;
      s_q.second_src <= iasu_pkg::DATA_RST;
      s_q.cmd <= iasu_pkg::iasu_cmd_t'(iasu_pkg::DATA_RST);
      s_q.result <= iasu_pkg::DATA_RST;
      s_q.flags <= iasu_pkg::FLAGS_RST;
      s_q.status <= 7'h00;
      s_q.exec_count <= iasu_pkg::DATA_RST;
      s_q.undef_count <= iasu_pkg::DATA_RST;
      s_q.rd_idx <= iasu_pkg::INDEX_RST;
      s_q.rd_we <= 1'b0;
      s_q.undef_pulse <= 1'b0;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= iasu_pkg::DATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign result_o = s_q.result;
  assign flags_o = s_q.flags;
  assign rd_idx_o = s_q.rd_idx;
  assign rd_we_o = s_q.rd_we;
  assign undef_o = s_q.undef_pulse;

endmodule : iasu_top

// [bench/iasu_chk.sv]
`timescale 1ns/1ps
module iasu_chk (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic issue_valid_i,
  input wire iasu_pkg::iasu_cmd_t issue_cmd_i,
  input wire logic [31:0] issue_first_src_i,
  input wire logic [31:0] issue_second_src_i,
  input wire logic [31:0] result_o,
  input wire iasu_pkg::iasu_flags_t flags_o,
  input wire logic [3:0] rd_idx_o,
  input wire logic rd_we_o,
  input wire logic undef_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // Result and flag values are judged only for issue-port runs, as APB runs carry no operand history.
  chk_issue_answer: assert property (issue_valid_i |=> rd_we_o || undef_o)
    else $error("Issued command got no answer.");
  chk_pulse_excl: assert property (!(rd_we_o && undef_o))
    else $error("Write and undefined pulses together.");
  chk_undef_hold: assert property (undef_o |-> $stable(result_o) &&
    $stable(flags_o) && $stable(rd_idx_o)) else $error("Undefined run wrote.");
  chk_plain_flags: assert property (issue_valid_i && !psel_i &&
    (issue_cmd_i.op == iasu_pkg::add_op || issue_cmd_i.op == iasu_pkg::sub_op)
    |=> $stable(flags_o)) else $error("Plain op changed flags.");
  chk_nz_flags: assert property (rd_we_o && $past(issue_valid_i) &&
    $past(issue_cmd_i.op) != iasu_pkg::add_op &&
    $past(issue_cmd_i.op) != iasu_pkg::sub_op |-> flags_o.n == result_o[31]
    && flags_o.z == (result_o == 32'h0)) else $error("N or Z flag wrong.");
  chk_carry_sum: assert property (rd_we_o && $past(issue_valid_i) &&
    $past(issue_cmd_i.op) == iasu_pkg::sum_with_carry_op |-> result_o ==
    $past(issue_first_src_i) + $past(issue_second_src_i) + $past(flags_o.c))
    else $error("Carry sum wrong.");
  chk_negate: assert property (rd_we_o && $past(issue_valid_i) &&
    $past(issue_cmd_i.op) == iasu_pkg::negate_from_zero_op |->
    result_o == 32'h0 - $past(issue_first_src_i)) else $error("Negate wrong.");
  chk_reg_sum: assert property (rd_we_o && $past(issue_valid_i) &&
    !$past(issue_cmd_i.use_imm) && $past(issue_cmd_i.op) inside
    {iasu_pkg::add_op, iasu_pkg::flagged_sum_op} |-> result_o ==
    $past(issue_first_src_i) + $past(issue_second_src_i))
    else $error("Register sum wrong.");
  chk_omit_dest: assert property (rd_we_o && $past(issue_valid_i) &&
    $past(issue_cmd_i.rd_omit) |->
    rd_idx_o == $past(issue_cmd_i.first_source_operand))
    else $error("Omitted destination wrong.");
  chk_apb_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("Access phase not answered.");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("Ready longer than one cycle.");
  chk_read_idle: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
    else $error("Read data outside answer.");
  cover property (rd_we_o && flags_o.c);
  cover property (undef_o);
  cover property (pready_o && pslverr_o);
endmodule : iasu_chk

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  logic ref_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, issue_valid_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, issue_first_src_i, issue_second_src_i;
  logic [31:0] result_o, exp_r, rdata;
  logic [3:0] pstrb_i, rd_idx_o, exp_rd;
  logic pready_o, pslverr_o, rd_we_o, undef_o, err;
  iasu_pkg::iasu_cmd_t issue_cmd_i;
  iasu_pkg::iasu_flags_t flags_o, exp_f;
  int fails, samples_checked;
  iasu_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .issue_valid_i(issue_valid_i),
    .issue_cmd_i(issue_cmd_i), .issue_first_src_i(issue_first_src_i),
    .issue_second_src_i(issue_second_src_i), .result_o(result_o),
    .flags_o(flags_o), .rd_idx_o(rd_idx_o), .rd_we_o(rd_we_o), .undef_o(undef_o));
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [35:0] seen, want, input string what);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, want);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // The answer is taken at the edge where pready is seen, never assumed.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rdata = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) begin
      fails++;
      stop_test();
    end
  endtask : apb
  function automatic iasu_pkg::iasu_cmd_t mk(input iasu_pkg::iasu_op_t op,
      input logic [3:0] rd, rn, rm, input logic ui, input logic [9:0] imm);
    mk = '{spare: 4'h0, imm: imm, rd_omit: 1'b0, use_imm: ui,
      second_source_operand: rm, first_source_operand: rn, rd: rd, op: op};
  endfunction : mk
  // Subtraction is fed in as a plus inverted b plus carry in.
  task automatic ex(input logic [31:0] a, b, input logic ci, up);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b} + {32'h0, ci};
    exp_r = s[31:0];
    if (up) begin
      exp_f = {s[31], s[31:0] == 32'h0, s[32], a[31] == b[31] && s[31] != a[31]};
    end
  endtask : ex
  task automatic run(input iasu_pkg::iasu_cmd_t c, input logic [31:0] a, b,
      input logic ok);
    @(posedge ref_clk_i);
    issue_valid_i <= 1'b1;
    issue_cmd_i <= c;
    issue_first_src_i <= a;
    issue_second_src_i <= b;
    @(posedge ref_clk_i);
    issue_valid_i <= 1'b0;
    #1;
    check(rd_we_o, ok, "write pulse");
    check(undef_o, !ok, "undefined pulse");
    check(result_o, exp_r, "result");
    check(flags_o, exp_f, "flags");
    check(rd_idx_o, exp_rd, "destination");
  endtask : run
  task automatic go(input iasu_pkg::iasu_cmd_t c, input logic [31:0] a, bd, bc,
      input logic ci, up);
    exp_rd = c.rd_omit ? c.first_source_operand : c.rd;
    ex(a, bc, ci, up);
    run(c, a, bd, 1'b1);
  endtask : go
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_apb();
    apb(1'b0, iasu_pkg::OFF_RESULT, 32'h0);
    check(rdata, 32'h0, "result reset");
    apb(1'b0, 12'h100, 32'h0);
    check({err, rdata}, {1'b1, 32'h0}, "unmapped");
    apb(1'b1, iasu_pkg::OFF_FLAGS, 32'ha);
    apb(1'b0, iasu_pkg::OFF_FLAGS, 32'h0);
    check(rdata, 32'ha, "flags readback");
    apb(1'b1, iasu_pkg::OFF_FIRST_SRC, 32'h10);
    apb(1'b1, iasu_pkg::OFF_SECOND_SRC, 32'h20);
    apb(1'b1, iasu_pkg::OFF_COMMAND, mk(iasu_pkg::flagged_sum_op, 1, 1, 2, 0, 0));
    apb(1'b0, iasu_pkg::OFF_RESULT, 32'h0);
    ex(32'h10, 32'h20, 1'b0, 1'b1);
    check(rdata, exp_r, "command result");
    check(flags_o, exp_f, "command flags");
    apb(1'b0, iasu_pkg::OFF_STATUS, 32'h0);
    check(rdata, 32'ha, "status");
    exp_rd = 4'h1;
    $display("t_apb finished");
  endtask : t_apb
  task automatic t_flagged();
    go(mk(iasu_pkg::flagged_sum_op, 1, 2, 0, 1, 7), 32'h7ffffffc, 32'h5a5a5a5a,
      32'h7, 1'b0, 1'b1);
    go(mk(iasu_pkg::flagged_sum_op, 3, 4, 5, 0, 0), 32'hffffffff, 32'h1, 32'h1,
      1'b0, 1'b1);
    go(mk(iasu_pkg::flagged_difference_op, 6, 6, 0, 1, 255), 32'hff, 32'h3,
      ~32'hff, 1'b1, 1'b1);
    go(mk(iasu_pkg::flagged_difference_op, 3, 4, 5, 0, 0), 32'h3, 32'h5, ~32'h5,
      1'b1, 1'b1);
    // Negate runs zero plus the inverted first source plus one.
    exp_rd = 4'h0;
    ex(32'h0, ~32'h1, 1'b1, 1'b1);
    run(mk(iasu_pkg::negate_from_zero_op, 0, 7, 0, 1, 0), 32'h1, 32'h9,
      1'b1);
    exp_rd = 4'h2;
    ex(32'h0, ~32'h80000000, 1'b1, 1'b1);
    run(mk(iasu_pkg::negate_from_zero_op, 2, 7, 0, 1, 0), 32'h80000000,
      32'h9, 1'b1);
    $display("t_flagged finished");
  endtask : t_flagged
  // Flags are left nonzero so that a wrongly cleared flag shows up.
  task automatic t_plain();
    go(mk(iasu_pkg::add_op, 9, 9, 14, 0, 0), 32'h100, 32'h23, 32'h23, 1'b0,
      1'b0);
    go(mk(iasu_pkg::add_op, 2, 15, 0, 1, 1020), 32'h1000, 32'h0, 32'h3fc, 1'b0,
      1'b0);
    go(mk(iasu_pkg::add_op, 13, 13, 0, 1, 508), 32'h1000, 32'h0, 32'h1fc, 1'b0,
      1'b0);
    go(mk(iasu_pkg::sub_op, 13, 13, 0, 1, 508), 32'h1000, 32'h0, ~32'h1fc, 1'b1,
      1'b0);
    $display("t_plain finished");
  endtask : t_plain
  task automatic t_carry();
    go(mk(iasu_pkg::flagged_sum_op, 0, 0, 2, 0, 0), 32'hffffffff, 32'h1, 32'h1,
      1'b0, 1'b1);
    go(mk(iasu_pkg::sum_with_carry_op, 1, 1, 3, 0, 0), 32'h1, 32'h2, 32'h2,
      exp_f.c, 1'b1);
    go(mk(iasu_pkg::sum_with_carry_op, 1, 1, 3, 0, 0), 32'h1, 32'h2, 32'h2,
      exp_f.c, 1'b1);
    go(mk(iasu_pkg::difference_with_carry_op, 5, 5, 2, 0, 0), 32'ha, 32'h4,
      ~32'h4, ~exp_f.c, 1'b1);
    go(mk(iasu_pkg::difference_with_carry_op, 5, 5, 2, 0, 0), 32'ha, 32'h4,
      ~32'h4, ~exp_f.c, 1'b1);
    $display("t_carry finished");
  endtask : t_carry
  task automatic t_omit();
    iasu_pkg::iasu_cmd_t c;
    c = mk(iasu_pkg::flagged_sum_op, 3, 5, 0, 1, 200);
    c.rd_omit = 1'b1;
    go(c, 32'h10, 32'h0, 32'hc8, 1'b0, 1'b1);
    $display("t_omit finished");
  endtask : t_omit
  task automatic t_illegal();
    iasu_pkg::iasu_cmd_t bad[12];
    bad = '{mk(iasu_pkg::sum_with_carry_op, 1, 2, 3, 0, 0),
      mk(iasu_pkg::flagged_sum_op, 1, 1, 8, 0, 0),
      mk(iasu_pkg::flagged_sum_op, 1, 2, 0, 1, 8),
      mk(iasu_pkg::flagged_difference_op, 1, 1, 0, 1, 256),
      mk(iasu_pkg::negate_from_zero_op, 1, 2, 0, 1, 1),
      mk(iasu_pkg::add_op, 2, 15, 0, 1, 1022),
      mk(iasu_pkg::add_op, 8, 13, 0, 1, 4),
      mk(iasu_pkg::add_op, 13, 13, 0, 1, 512),
      mk(iasu_pkg::add_op, 15, 15, 15, 0, 0),
      mk(iasu_pkg::sub_op, 1, 1, 2, 0, 0),
      mk(iasu_pkg::difference_with_carry_op, 1, 1, 9, 0, 0),
      mk(iasu_pkg::iasu_op_t'(4'h7), 1, 1, 2, 0, 0)};
    foreach (bad[i]) begin
      run(bad[i], 32'h11, 32'h22, 1'b0);
    end
    $display("t_illegal finished");
  endtask : t_illegal
  initial begin
    rst_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    pstrb_i = 4'hf;
    issue_valid_i = 1'b0;
    issue_cmd_i = '0;
    issue_first_src_i = 32'h0;
    issue_second_src_i = 32'h0;
    exp_f = 4'ha;
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_apb();
    t_flagged();
    t_plain();
    t_carry();
    t_omit();
    t_illegal();
    stop_test();
  end
endmodule : tb
bind iasu_top iasu_chk u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .issue_valid_i(issue_valid_i), .issue_cmd_i(issue_cmd_i),
  .issue_first_src_i(issue_first_src_i),
  .issue_second_src_i(issue_second_src_i), .result_o(result_o),
  .flags_o(flags_o), .rd_idx_o(rd_idx_o), .rd_we_o(rd_we_o), .undef_o(undef_o));
